// ==== verilog/bpt_pkg.sv ====
package bpt_pkg;

    // ------------------------------------------------------------------
    // Register offsets (word addresses as printed).
    // ------------------------------------------------------------------
    localparam logic [15:0] BPT_OFS_DCFG = 16'h0200;
    localparam logic [15:0] BPT_OFS_DATA_PORT_ERROR = 16'h0202;
    localparam logic [15:0] BPT_OFS_INSTR_PORT_ERROR = 16'h0302;
    localparam logic [15:0] BPT_OFS_SCFG = 16'h07FD;
    localparam logic [15:0] BPT_OFS_TIMEOUT_CONTROL = 16'h9000;
    localparam logic [15:0] BPT_OFS_ISTAT = 16'h9010;
    localparam logic [15:0] BPT_OFS_IMASK = 16'h9012;
    localparam logic [15:0] BPT_OFS_IDLE = 16'h9014;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int BPT_WPE_BIT = 7;
    localparam int BPT_TOFLAG_BIT = 12;
    localparam int BPT_CPRES_BIT = 5;
    localparam int BPT_RSV_RW_BIT = 4;
    localparam int BPT_EMTOEN_BIT = 1;
    localparam int BPT_PERTOEN_BIT = 0;

    // Status/mask bits of the event register.
    localparam int BPT_EV_EXTTO = 0;
    localparam int BPT_EV_FETCHTO = 1;
    localparam int BPT_EV_PERTO = 2;
    localparam int BPT_EV_DMATO = 3;
    localparam int BPT_EV_IDLEERR = 4;
    localparam int BPT_EV_W = 5;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [15:0] BPT_SCFG_RST = 16'h8200;
    localparam logic BPT_EMTOEN_RST = 1'b0;
    localparam logic BPT_PERTOEN_RST = 1'b1;

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int BPT_TO_CYCLES = 512;
    localparam int BPT_CNT_W = 10;

endpackage : bpt_pkg

// ==== verilog/bpt_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Stall watchdog: restarts at each new access, fires once past the limit.
module bpt_timer
    import bpt_pkg::*;
#(
    parameter int LIMIT = BPT_TO_CYCLES
)(
    input wire logic clk_in, // Clock.
    input wire logic resetn_in, // Async reset, active low.
    input wire logic ce_in, // Clock enable.
    input wire logic start_in, // New access begins.
    input wire logic busy_in, // Access still outstanding.
    input wire logic arm_in, // Watchdog enabled.
    output logic fire_out // One-cycle time-out pulse.
);

    typedef struct packed
    {
        logic [BPT_CNT_W:0] cnt;
        logic fired;
        logic fire;
    } bpt_tmr_s;

    bpt_tmr_s st_r;
    bpt_tmr_s st_nxt;

    // Count stalled cycles; the fired flag stops a second pulse per access.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.fire = 1'b0;
        if (start_in)
        begin
            st_nxt.cnt = '0;
            st_nxt.fired = 1'b0;
        end
        else if (busy_in && !st_r.fired)
        begin
            if (st_r.cnt >= (BPT_CNT_W+1)'(LIMIT - 1))
            begin
                st_nxt.fire = arm_in;
                st_nxt.fired = 1'b1;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
        else if (!busy_in)
        begin
            st_nxt.cnt = '0;
        end
    end

    // State register.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            st_r <= '0;
        else if (ce_in)
            st_r <= st_nxt;
    end

    assign fire_out = st_r.fire;

endmodule : bpt_timer

`default_nettype wire

// ==== verilog/bpt_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Data port config bit 7 is read/write write-post enable, reset 0.
// - Data port error bit 12 flags external memory time-out, read-only.
// - Instruction port error bit 12 flags fetch time-out, read-only.
// - Fetch time-out detection is armed by the external memory enable.
// - Instruction port idles on request plus idle only with no fetch pending.
// - Idle instruction port takes no requests; they stall with no answer.
// - Idling the instruction port without CPU idle sets the idle error status flag.
// - System configuration bit 5 reports cache present and working.
// - Idle peripheral access unanswered 512 cycles times out if enabled.
// - Time-out to the CPU raises a CPU bus error interrupt.
// - DMA time-out sets DMA status flag and raises an error.
// - Time-out control bit 1 enables external stall time-out, reset 0.
// - Time-out control bit 0 enables peripheral time-out, reset 1.
// - Posting holds two writes; CPU stalls only when both are full.
module bpt_top
    import bpt_pkg::*;
#(
    parameter int TO_LIMIT = BPT_TO_CYCLES
)(
    input wire logic clk_in, // 40 MHz clock.
    input wire logic resetn_in, // Async reset, active low.
    input wire logic ce_in, // Clock enable.
    input wire logic [15:0] addr_in, // Register address.
    input wire logic [15:0] wdata_in, // Write data.
    input wire logic wr_in, // Write strobe.
    input wire logic rd_in, // Read strobe.
    output logic [15:0] rdata_out, // Read data, cycle after rd_in.
    output logic irq_out, // Level interrupt.
    // Data port side towards the external memory interface.
    input wire logic dp_wr_req_in, // CPU external write request.
    input wire logic ext_done_in, // Memory interface retired a post.
    input wire logic ext_start_in, // New external access begins.
    input wire logic ext_busy_in, // External access outstanding.
    output logic dp_stall_out, // CPU write stall.
    output logic [1:0] post_cnt_out, // Occupied posting slots.
    output logic post_en_out, // Write posting enabled.
    // Instruction port side.
    input wire logic fetch_req_in, // Cache fetch request.
    input wire logic fetch_start_in, // New fetch to external memory.
    input wire logic fetch_busy_in, // Fetch outstanding.
    output logic fetch_ack_out, // Fetch request accepted.
    input wire logic idle_exec_in, // Idle instruction executed.
    input wire logic cpu_idle_in, // CPU domain is idle.
    output logic instruction_port_idle_out, // Instruction port is idle.
    input wire logic cache_ok_in, // Cache enabled and working.
    // Peripheral watchdog.
    input wire logic per_start_in, // New access to idle peripheral.
    input wire logic per_busy_in, // Awaiting peripheral ack.
    input wire logic per_is_dma_in, // Requester is the DMA.
    output logic cpu_bus_error_interrupt_out, // CPU bus error pulse.
    output logic dma_to_out // DMA time-out pulse.
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        BPT_IP_RUN = 2'b00,
        BPT_IP_WAIT = 2'b01,
        BPT_IP_IDLE = 2'b10
    } bpt_ip_e;

    typedef struct packed
    {
        logic write_post_enable;
        logic emtoen;
        logic pertoen;
        logic rsv4;
        logic ext_to;
        logic fetch_to;
        logic idle_req;
        logic [BPT_EV_W-1:0] stat;
        logic [BPT_EV_W-1:0] mask;
        logic [1:0] posts;
        bpt_ip_e ip;
        logic bus_error_interrupt;
        logic dma_to;
        logic [15:0] rdata;
    } bpt_top_s;

    bpt_top_s st_r;
    bpt_top_s st_nxt;

    logic ext_fire;
    logic fetch_fire;
    logic per_fire;

    // Place a single flag at its bit inside a 16-bit word.
    function automatic logic [15:0] bpt_bit(input logic v, input int pos);
        logic [15:0] w;
        w = '0;
        w[pos] = v;
        return w;
    endfunction : bpt_bit

    // ------------------------------------------------------------------
    // Watchdogs.
    // ------------------------------------------------------------------
    // External memory stalls from the data port side.
    bpt_timer #(.LIMIT(TO_LIMIT)) u_ext_tmr (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .start_in(ext_start_in),
        .busy_in(ext_busy_in),
        .arm_in(st_r.emtoen),
        .fire_out(ext_fire)
    );

    // Fetch stalls share the external memory enable.
    bpt_timer #(.LIMIT(TO_LIMIT)) u_fetch_tmr (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .start_in(fetch_start_in),
        .busy_in(fetch_busy_in),
        .arm_in(st_r.emtoen),
        .fire_out(fetch_fire)
    );

    // Accesses to disabled or idle peripherals.
    bpt_timer #(.LIMIT(TO_LIMIT)) u_per_tmr (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .start_in(per_start_in),
        .busy_in(per_busy_in),
        .arm_in(st_r.pertoen),
        .fire_out(per_fire)
    );

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [BPT_EV_W-1:0] ev;
        logic idle_err;
        logic push;
        ev = '0;
        idle_err = 1'b0;
        push = 1'b0;
        st_nxt = st_r;
        st_nxt.bus_error_interrupt = 1'b0;
        st_nxt.dma_to = 1'b0;

        // Register writes.
        if (wr_in)
        begin
            case (addr_in)
                BPT_OFS_DCFG: st_nxt.write_post_enable = wdata_in[BPT_WPE_BIT];
                BPT_OFS_SCFG: st_nxt.rsv4 = wdata_in[BPT_RSV_RW_BIT];
                BPT_OFS_TIMEOUT_CONTROL:
                begin
                    st_nxt.emtoen = wdata_in[BPT_EMTOEN_BIT];
                    st_nxt.pertoen = wdata_in[BPT_PERTOEN_BIT];
                end
                BPT_OFS_IMASK: st_nxt.mask = wdata_in[BPT_EV_W-1:0];
                BPT_OFS_IDLE: st_nxt.idle_req = wdata_in[0];
                BPT_OFS_ISTAT:
                    st_nxt.stat = st_r.stat & ~wdata_in[BPT_EV_W-1:0];
                default: st_nxt.stat = st_nxt.stat;
            endcase
        end

        // Posting slots: a pushed write waits only when both are taken.
        push = dp_wr_req_in && st_r.write_post_enable && (st_r.posts != 2'd2);
        case ({push, ext_done_in && (st_r.posts != 2'd0)})
            2'b10: st_nxt.posts = st_r.posts + 2'd1;
            2'b01: st_nxt.posts = st_r.posts - 2'd1;
            default: st_nxt.posts = st_r.posts;
        endcase

        // Instruction port idle sequence.
        case (st_r.ip)
            BPT_IP_RUN:
                if (st_r.idle_req && idle_exec_in)
                begin
                    st_nxt.ip = BPT_IP_WAIT;
                    idle_err = !cpu_idle_in;
                end
            BPT_IP_WAIT:
                if (!fetch_req_in && !fetch_busy_in)
                    st_nxt.ip = BPT_IP_IDLE;
            BPT_IP_IDLE:
                if (!st_r.idle_req)
                    st_nxt.ip = BPT_IP_RUN;
            default: st_nxt.ip = BPT_IP_RUN;
        endcase

        // Sticky error flags, held until reset.
        if (ext_fire)
            st_nxt.ext_to = 1'b1;
        if (fetch_fire)
            st_nxt.fetch_to = 1'b1;

        // Peripheral time-out goes to whoever asked.
        if (per_fire)
        begin
            st_nxt.bus_error_interrupt = !per_is_dma_in;
            st_nxt.dma_to = per_is_dma_in;
        end

        // Events set status after the clear so a same-cycle set wins.
        ev[BPT_EV_EXTTO] = ext_fire;
        ev[BPT_EV_FETCHTO] = fetch_fire;
        ev[BPT_EV_PERTO] = per_fire && !per_is_dma_in;
        ev[BPT_EV_DMATO] = per_fire && per_is_dma_in;
        ev[BPT_EV_IDLEERR] = idle_err;
        st_nxt.stat = st_nxt.stat | ev;

        // Read data, registered for the cycle after the strobe.
        st_nxt.rdata = '0;
        if (rd_in)
        begin
            case (addr_in)
                BPT_OFS_DCFG: st_nxt.rdata = bpt_bit(st_r.write_post_enable, BPT_WPE_BIT);
                BPT_OFS_DATA_PORT_ERROR:
                    st_nxt.rdata = bpt_bit(st_r.ext_to, BPT_TOFLAG_BIT);
                BPT_OFS_INSTR_PORT_ERROR:
                    st_nxt.rdata = bpt_bit(st_r.fetch_to, BPT_TOFLAG_BIT);
                BPT_OFS_SCFG:
                    st_nxt.rdata = BPT_SCFG_RST
                        | bpt_bit(cache_ok_in, BPT_CPRES_BIT)
                        | bpt_bit(st_r.rsv4, BPT_RSV_RW_BIT);
                BPT_OFS_TIMEOUT_CONTROL:
                    st_nxt.rdata = bpt_bit(st_r.emtoen, BPT_EMTOEN_BIT)
                        | bpt_bit(st_r.pertoen, BPT_PERTOEN_BIT);
                BPT_OFS_ISTAT: st_nxt.rdata = {11'h000, st_r.stat};
                BPT_OFS_IMASK: st_nxt.rdata = {11'h000, st_r.mask};
                BPT_OFS_IDLE:
                    st_nxt.rdata = {14'h0000, st_r.ip == BPT_IP_IDLE,
                        st_r.idle_req};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_r <= '0;
            st_r.emtoen <= BPT_EMTOEN_RST;
            st_r.pertoen <= BPT_PERTOEN_RST;
            st_r.ip <= BPT_IP_RUN;
        end
        else if (ce_in)
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    // Stalls are combinational so the CPU is held in the same cycle.
    assign rdata_out = st_r.rdata;
    assign irq_out = |(st_r.stat & st_r.mask);
    assign dp_stall_out = dp_wr_req_in && st_r.write_post_enable && (st_r.posts == 2'd2);
    assign post_cnt_out = st_r.posts;
    assign post_en_out = st_r.write_post_enable;
    // An idle port never answers, so the requester hangs.
    assign fetch_ack_out = fetch_req_in && (st_r.ip != BPT_IP_IDLE);
    assign instruction_port_idle_out = (st_r.ip == BPT_IP_IDLE);
    assign cpu_bus_error_interrupt_out = st_r.bus_error_interrupt;
    assign dma_to_out = st_r.dma_to;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // Idle request and idle instruction seen while the port still runs.
    sequence s_idle_go;
        st_r.idle_req && idle_exec_in && ce_in && st_r.ip == BPT_IP_RUN;
    endsequence

    AST_WPE_WRITE: assert property (
        ce_in && wr_in && addr_in == BPT_OFS_DCFG
        |=> post_en_out == $past(wdata_in[BPT_WPE_BIT]))
        else $error("Posting enable not stored.");

    AST_TIMEOUT_CONTROL_WRITE: assert property (
        ce_in && wr_in && addr_in == BPT_OFS_TIMEOUT_CONTROL
        |=> st_r.emtoen == $past(wdata_in[BPT_EMTOEN_BIT])
        && st_r.pertoen == $past(wdata_in[BPT_PERTOEN_BIT]))
        else $error("Time-out control not stored.");

    AST_TIMEOUT_CONTROL_RST: assert property (
        $rose(resetn_in) |-> st_r.pertoen && !st_r.emtoen)
        else $error("Time-out control reset wrong.");

    AST_EXT_SET: assert property (
        ce_in && ext_fire |=> st_r.ext_to && st_r.stat[BPT_EV_EXTTO])
        else $error("External time-out flag not set.");

    AST_EXT_STICKY: assert property (
        st_r.ext_to |=> st_r.ext_to)
        else $error("External time-out flag dropped.");

    AST_FETCH_SET: assert property (
        ce_in && fetch_fire |=> st_r.fetch_to)
        else $error("Fetch time-out flag not set.");

    AST_FETCH_STICKY: assert property (
        st_r.fetch_to |=> st_r.fetch_to)
        else $error("Fetch time-out flag dropped.");

    AST_CPRES_READ: assert property (
        ce_in && rd_in && addr_in == BPT_OFS_SCFG
        |=> rdata_out[BPT_CPRES_BIT] == $past(cache_ok_in))
        else $error("Cache present bit misread.");

    AST_IDLE_ERR: assert property (
        s_idle_go ##0 !cpu_idle_in |=> st_r.stat[BPT_EV_IDLEERR])
        else $error("Idle error not raised.");

    AST_NO_ACK_IDLE: assert property (
        instruction_port_idle_out |-> !fetch_ack_out)
        else $error("Idle port answered a fetch.");

    AST_IDLE_WAIT: assert property (
        st_r.ip == BPT_IP_WAIT && (fetch_req_in || fetch_busy_in)
        |=> !instruction_port_idle_out)
        else $error("Port idled with fetch pending.");

    AST_CPU_BUS_ERROR_INTERRUPT: assert property (
        ce_in && per_fire && !per_is_dma_in
        |=> cpu_bus_error_interrupt_out && st_r.stat[BPT_EV_PERTO])
        else $error("CPU bus error missing.");

    AST_DMA_TO: assert property (
        ce_in && per_fire && per_is_dma_in
        |=> dma_to_out && !cpu_bus_error_interrupt_out)
        else $error("DMA time-out missing.");

    AST_STALL: assert property (
        dp_stall_out |-> post_cnt_out == 2'd2)
        else $error("Stall with a free posting slot.");

endmodule : bpt_top

`default_nettype wire

// ==== tb/bpt_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Far side of one access path: one start pulse, then busy until it answers.
module bpt_far_model (
    input wire logic clk_in, // Clock.
    input wire logic resetn_in, // Async reset, active low.
    input wire logic go_in, // Launch one access.
    input wire logic [7:0] len_in, // Busy cycles before the answer.
    output logic start_out, // New access pulse.
    output logic busy_out, // Access outstanding.
    output logic done_out // Access answered pulse.
);
    logic [7:0] cnt_r;

    // A long count stands for a stalled memory or an idle peripheral that
    // never answers in time; a new launch drops the old access at once.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            start_out <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            cnt_r <= 8'h00;
        end
        else
        begin
            start_out <= go_in;
            done_out <= 1'b0;
            if (go_in)
            begin
                cnt_r <= len_in;
                busy_out <= 1'b0;
            end
            else if (cnt_r != 8'h00)
            begin
                busy_out <= 1'b1;
                cnt_r <= cnt_r - 8'h01;
            end
            else
            begin
                done_out <= busy_out;
                busy_out <= 1'b0;
            end
        end
    end
endmodule : bpt_far_model

`default_nettype wire

// ==== tb/test_bpt_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_bpt_top;
    import bpt_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int LIM = 8;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic ce_in = 1'b1;
    logic [15:0] addr_in = 16'h0000;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic dp_wr_req_in = 1'b0;
    logic fetch_req_in = 1'b0;
    logic idle_exec_in = 1'b0;
    logic cpu_idle_in = 1'b0;
    logic cache_ok_in = 1'b0;
    logic per_is_dma_in = 1'b0;
    logic [2:0] far_go = 3'h0;
    logic [7:0] far_len = 8'h00;
    logic [15:0] rdata_out;
    logic [1:0] post_cnt_out;
    logic irq_out, dp_stall_out, post_en_out, fetch_ack_out;
    logic instruction_port_idle_out, cpu_bus_error_interrupt_out, dma_to_out;
    logic ext_done_in, ext_start_in, ext_busy_in;
    logic fetch_start_in, fetch_busy_in, per_start_in, per_busy_in;
    int num_errors = 0;
    int num_checks = 0;

    // Free-running clock, 25 ns period.
    always #12.5 clk_in = ~clk_in;

    // Short watchdog limit keeps every time-out run brief.
    bpt_top #(.TO_LIMIT(LIM)) u_dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
        .dp_wr_req_in(dp_wr_req_in), .ext_done_in(ext_done_in),
        .ext_start_in(ext_start_in), .ext_busy_in(ext_busy_in),
        .dp_stall_out(dp_stall_out), .post_cnt_out(post_cnt_out),
        .post_en_out(post_en_out), .fetch_req_in(fetch_req_in),
        .fetch_start_in(fetch_start_in), .fetch_busy_in(fetch_busy_in),
        .fetch_ack_out(fetch_ack_out), .idle_exec_in(idle_exec_in),
        .cpu_idle_in(cpu_idle_in), .instruction_port_idle_out(instruction_port_idle_out),
        .cache_ok_in(cache_ok_in), .per_start_in(per_start_in),
        .per_busy_in(per_busy_in), .per_is_dma_in(per_is_dma_in),
        .cpu_bus_error_interrupt_out(cpu_bus_error_interrupt_out), .dma_to_out(dma_to_out));

    // Far-side models for external memory, fetch and peripheral paths.
    bpt_far_model u_ext (.clk_in(clk_in), .resetn_in(resetn_in),
        .go_in(far_go[0]), .len_in(far_len), .start_out(ext_start_in),
        .busy_out(ext_busy_in), .done_out(ext_done_in));
    bpt_far_model u_fch (.clk_in(clk_in), .resetn_in(resetn_in),
        .go_in(far_go[1]), .len_in(far_len), .start_out(fetch_start_in),
        .busy_out(fetch_busy_in), .done_out());
    bpt_far_model u_per (.clk_in(clk_in), .resetn_in(resetn_in),
        .go_in(far_go[2]), .len_in(far_len), .start_out(per_start_in),
        .busy_out(per_busy_in), .done_out());

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : check16

    task automatic check1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : check1

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    // Read data is sampled in the one cycle where it stands.
    task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        check16(rdata_out, exp);
    endtask : rchk

    task automatic launch(input int w, input logic [7:0] n);
        @(posedge clk_in);
        far_go[w] <= 1'b1;
        far_len <= n;
        @(posedge clk_in);
        far_go[w] <= 1'b0;
    endtask : launch

    task automatic watch(input int n, output logic b, output logic d);
        b = 1'b0;
        d = 1'b0;
        repeat (n)
        begin
            @(posedge clk_in);
            #1;
            b = b | cpu_bus_error_interrupt_out;
            d = d | dma_to_out;
        end
    endtask : watch

    task automatic wait_idle(input logic exp);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk_in);
            #1;
            if (instruction_port_idle_out === exp)
                break;
        end
        check1(instruction_port_idle_out, exp);
        if (instruction_port_idle_out !== exp)
            print_verdict();
    endtask : wait_idle

    task automatic go_idle;
        wr(BPT_OFS_IDLE, 16'h0001);
        @(posedge clk_in);
        idle_exec_in <= 1'b1;
        @(posedge clk_in);
        idle_exec_in <= 1'b0;
    endtask : go_idle

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rchk(BPT_OFS_TIMEOUT_CONTROL, 16'h0001);
        rchk(BPT_OFS_DCFG, 16'h0000);
        rchk(BPT_OFS_DATA_PORT_ERROR, 16'h0000);
        rchk(BPT_OFS_INSTR_PORT_ERROR, 16'h0000);
        rchk(BPT_OFS_SCFG, 16'h8200);
        rchk(16'h0100, 16'h0000);
        wr(BPT_OFS_DCFG, 16'hFFFF);
        rchk(BPT_OFS_DCFG, 16'h0080);
        check1(post_en_out, 1'b1);
        wr(BPT_OFS_DATA_PORT_ERROR, 16'hFFFF);
        wr(BPT_OFS_INSTR_PORT_ERROR, 16'hFFFF);
        rchk(BPT_OFS_DATA_PORT_ERROR, 16'h0000);
        rchk(BPT_OFS_INSTR_PORT_ERROR, 16'h0000);
        cache_ok_in <= 1'b1;
        wr(BPT_OFS_SCFG, 16'h0000);
        rchk(BPT_OFS_SCFG, 16'h8220);
        wr(BPT_OFS_TIMEOUT_CONTROL, 16'hFFFF);
        rchk(BPT_OFS_TIMEOUT_CONTROL, 16'h0003);
        wr(BPT_OFS_TIMEOUT_CONTROL, 16'h0001);
        ce_in <= 1'b0;
        wr(BPT_OFS_TIMEOUT_CONTROL, 16'h0000);
        ce_in <= 1'b1;
        rchk(BPT_OFS_TIMEOUT_CONTROL, 16'h0001);
        wr(BPT_OFS_IMASK, 16'h001F);
    endtask : t_regs

    // Two posts fill both slots; a third request stalls, is dropped, then one post retires.
    task automatic t_post;
        @(posedge clk_in);
        dp_wr_req_in <= 1'b1;
        tick(2);
        #1;
        check16({14'h0000, post_cnt_out}, 16'h0002);
        check1(dp_stall_out, 1'b1);
        @(posedge clk_in);
        dp_wr_req_in <= 1'b0;
        launch(0, 8'h01);
        tick(4);
        #1;
        check16({14'h0000, post_cnt_out}, 16'h0001);
        wr(BPT_OFS_DCFG, 16'h0000);
        dp_wr_req_in <= 1'b1;
        tick(2);
        #1;
        check1(post_en_out, 1'b0);
        check1(dp_stall_out, 1'b0);
        dp_wr_req_in <= 1'b0;
    endtask : t_post

    task automatic t_per(input logic dma);
        logic b, d;
        per_is_dma_in <= dma;
        launch(2, 8'd40);
        watch(LIM + 10, b, d);
        check1(b, !dma);
        check1(d, dma);
        rchk(BPT_OFS_ISTAT, dma ? 16'h0008 : 16'h0004);
        check1(irq_out, 1'b1);
        wr(BPT_OFS_IMASK, 16'h0000);
        #1;
        check1(irq_out, 1'b0);
        wr(BPT_OFS_IMASK, 16'h001F);
        wr(BPT_OFS_ISTAT, 16'h001F);
        rchk(BPT_OFS_ISTAT, 16'h0000);
        check1(irq_out, 1'b0);
    endtask : t_per

    task automatic t_per_quiet;
        logic b, d;
        per_is_dma_in <= 1'b0;
        wr(BPT_OFS_TIMEOUT_CONTROL, 16'h0000);
        launch(2, 8'd40);
        watch(LIM + 10, b, d);
        check1(b, 1'b0);
        wr(BPT_OFS_TIMEOUT_CONTROL, 16'h0001);
        launch(2, 8'd6);
        tick(5);
        launch(2, 8'd6);
        watch(LIM + 10, b, d);
        check1(b, 1'b0);
    endtask : t_per_quiet

    task automatic t_ext;
        launch(0, 8'd40);
        launch(1, 8'd40);
        tick(LIM + 10);
        rchk(BPT_OFS_DATA_PORT_ERROR, 16'h0000);
        rchk(BPT_OFS_INSTR_PORT_ERROR, 16'h0000);
        wr(BPT_OFS_TIMEOUT_CONTROL, 16'h0003);
        launch(0, 8'd40);
        tick(LIM + 10);
        rchk(BPT_OFS_DATA_PORT_ERROR, 16'h1000);
        launch(1, 8'd40);
        tick(LIM + 10);
        rchk(BPT_OFS_INSTR_PORT_ERROR, 16'h1000);
        wr(BPT_OFS_TIMEOUT_CONTROL, 16'h0001);
        tick(40);
        rchk(BPT_OFS_DATA_PORT_ERROR, 16'h1000);
        wr(BPT_OFS_ISTAT, 16'h001F);
    endtask : t_ext

    task automatic t_idle;
        @(posedge clk_in);
        fetch_req_in <= 1'b1;
        go_idle();
        tick(3);
        #1;
        check1(instruction_port_idle_out, 1'b0);
        check1(fetch_ack_out, 1'b1);
        fetch_req_in <= 1'b0;
        wait_idle(1'b1);
        @(posedge clk_in);
        fetch_req_in <= 1'b1;
        #1;
        check1(fetch_ack_out, 1'b0);
        rchk(BPT_OFS_ISTAT, 16'h0010);
        check1(irq_out, 1'b1);
        wr(BPT_OFS_ISTAT, 16'h001F);
        wr(BPT_OFS_IDLE, 16'h0000);
        wait_idle(1'b0);
        check1(fetch_ack_out, 1'b1);
        @(posedge clk_in);
        fetch_req_in <= 1'b0;
        cpu_idle_in <= 1'b1;
        go_idle();
        wait_idle(1'b1);
        rchk(BPT_OFS_ISTAT, 16'h0000);
        wr(BPT_OFS_IDLE, 16'h0000);
        wait_idle(1'b0);
    endtask : t_idle

    // Main sequence: reset for 20 cycles, then every scenario in turn.
    initial
    begin
        tick(20);
        resetn_in <= 1'b1;
        t_regs();
        t_post();
        t_per(1'b0);
        t_per(1'b1);
        t_per_quiet();
        t_ext();
        t_idle();
        print_verdict();
    end

    // Cuts a hang short well inside the cycle budget.
    initial
    begin
        #2000000;
        num_errors++;
        $display("wrong value at %0t: run timed out", $time);
        print_verdict();
    end
endmodule : test_bpt_top

`default_nettype wire
